// ===== design/abu_consts.svh
`ifndef ABU_CONSTS_SVH
`define ABU_CONSTS_SVH
// register indices on the plain register port
`define ABU_ADDR_STATUS_CONTROL 3'h0
`define ABU_ADDR_ADDR_HIGH 3'h1
`define ABU_ADDR_ADDR_LOW 3'h2
`define ABU_ADDR_WAKEUP_STATUS 3'h3
`define ABU_ADDR_FLAG_CLEAR 3'h4
`define ABU_ADDR_IRQ_STATUS 3'h5
`define ABU_ADDR_IRQ_MASK 3'h6
// field positions
`define ABU_BIT_ENABLE 7
`define ABU_BIT_ACTIVE 6
`define ABU_BIT_WAKEUP 1
`define ABU_BIT_CLEAR_EN 7
`define ABU_IRQ_MATCH 0
`define ABU_IRQ_SOFT 1
`define ABU_IRQ_WAKE 2
// reset values
`define ABU_RST_BYTE 8'h00
`define ABU_RST_IRQ 3'h0
// break vectors
`define ABU_VEC_NORMAL 16'hfffc
`define ABU_VEC_MONITOR 16'hfefc
`endif

// ===== design/abu_pkg.sv
package abu_pkg;
    typedef enum logic [1:0] {
        ABU_IDLE = 2'b00,
        ABU_PEND = 2'b01,
        ABU_BREAK = 2'b10
    } abu_state_t;
endpackage : abu_pkg

// ===== design/abu_sync.sv
`timescale 1ns/1ps
// three-stage input synchroniser; output changes once stages two and three agree
module abu_sync (
    clk,
    rst,
    din,
    dout
);
    input wire logic clk;
    input wire logic rst;
    input wire logic din;
    output logic dout;
    logic [2:0] stage_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage_q <= 3'h0;
        end else begin
            stage_q <= {stage_q[1:0], din};
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout <= 1'b0;
        end else if (stage_q[1] == stage_q[2]) begin
            dout <= stage_q[2];
        end
    end
endmodule : abu_sync

// ===== design/address_breakpoint_unit.sv
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "abu_consts.svh"
// Functional notes
// - raise break request when address bus equals the two breakpoint bytes
// - only program-counter fetch addresses from the CPU may match
// - core finishes instruction, then takes software interrupt at vector FFFC or FEFC
// - match on last instruction cycle starts the break at once
// - software writing one to break-active forces a break
// - break-active set on match, readable, cleared by zero write and reset
// - break-enable at bit 7 gates address breaks; read/write, reset clears
// - return-from-interrupt inside the break routine ends the break state
// - two address bytes held, both zero after reset
// - both timer counters halt during a break
// - comparator keeps working in wait mode so a match ends wait
// - a break wakes the device from stop and sets wakeup flag
// - wakeup flag set when break ends wait or stop; zero write and reset clear
// - other status flags clearable in break only while clear-enable set
module address_breakpoint_unit
    import abu_pkg::*;
(
    clk,
    rst,
    regAddr,
    regWrData,
    regWr,
    regRd,
    regRdData,
    cpuAddr,
    cpuPcFetch,
    cpuLastCycle,
    cpuRtiExec,
    cpuInWait,
    cpuInStop,
    monitorMode,
    testHighVoltage,
    breakRequest,
    breakVector,
    breakActive,
    lowPowerExit,
    timerHalt,
    watchdogHold,
    flagClearAllow,
    irq
);
    input wire logic clk;
    input wire logic rst;
    input wire logic [2:0] regAddr;
    input wire logic [7:0] regWrData;
    input wire logic regWr;
    input wire logic regRd;
    output logic [7:0] regRdData;
    input wire logic [15:0] cpuAddr;
    input wire logic cpuPcFetch;
    input wire logic cpuLastCycle;
    input wire logic cpuRtiExec;
    input wire logic cpuInWait;
    input wire logic cpuInStop;
    input wire logic monitorMode;
    input wire logic testHighVoltage;
    output logic breakRequest;
    output logic [15:0] breakVector;
    output logic breakActive;
    output logic lowPowerExit;
    output logic timerHalt;
    output logic watchdogHold;
    output logic flagClearAllow;
    output logic irq;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic enable_q;
    logic active_q;
    logic [7:0] addrHigh_q;
    logic [7:0] addrLow_q;
    logic wakeup_q;
    logic clearEn_q;
    logic [2:0] irqStatus_q;
    logic [2:0] irqMask_q;
    abu_state_t state_q;
    logic tstSync;

    // test voltage comes from a pin, so it is synchronised
    abu_sync u_tst_sync (
        .clk(clk),
        .rst(rst),
        .din(testHighVoltage),
        .dout(tstSync)
    );

    logic wrCtl;
    logic wrHigh;
    logic wrLow;
    logic wrWake;
    logic wrClr;
    logic wrIrqSt;
    logic wrIrqMask;
    logic matchHit;
    logic softBreak;
    logic breakStart;
    logic inLowPower;

    assign wrCtl = regWr && (regAddr == `ABU_ADDR_STATUS_CONTROL);
    assign wrHigh = regWr && (regAddr == `ABU_ADDR_ADDR_HIGH);
    assign wrLow = regWr && (regAddr == `ABU_ADDR_ADDR_LOW);
    assign wrWake = regWr && (regAddr == `ABU_ADDR_WAKEUP_STATUS);
    assign wrClr = regWr && (regAddr == `ABU_ADDR_FLAG_CLEAR);
    assign wrIrqSt = regWr && (regAddr == `ABU_ADDR_IRQ_STATUS);
    assign wrIrqMask = regWr && (regAddr == `ABU_ADDR_IRQ_MASK);

    // comparator has no gating on wait, so it stays live in wait mode
    assign matchHit = enable_q && cpuPcFetch && (cpuAddr == {addrHigh_q, addrLow_q});
    assign softBreak = wrCtl && regWrData[`ABU_BIT_ACTIVE];
    assign inLowPower = cpuInWait || cpuInStop;
    assign breakStart = (state_q == ABU_IDLE) && (matchHit || softBreak);

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_q <= 1'b0;
        end else if (wrCtl) begin
            enable_q <= regWrData[`ABU_BIT_ENABLE];
        end
    end

    // hardware set wins over a simultaneous zero write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_q <= 1'b0;
        end else if (matchHit || softBreak) begin
            active_q <= 1'b1;
        end else if (wrCtl) begin
            active_q <= regWrData[`ABU_BIT_ACTIVE];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addrHigh_q <= `ABU_RST_BYTE;
            addrLow_q <= `ABU_RST_BYTE;
        end else begin
            if (wrHigh) begin
                addrHigh_q <= regWrData;
            end
            if (wrLow) begin
                addrLow_q <= regWrData;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clearEn_q <= 1'b0;
        end else if (wrClr) begin
            clearEn_q <= regWrData[`ABU_BIT_CLEAR_EN];
        end
    end

    // ------------------------------------------------------------
    // break sequencing
    // ------------------------------------------------------------
    // a pending break waits for the last cycle of the running instruction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ABU_IDLE;
        end else begin
            unique case (state_q)
                ABU_IDLE: begin
                    if (breakStart) begin
                        state_q <= (cpuLastCycle || inLowPower) ? ABU_BREAK : ABU_PEND;
                    end
                end
                ABU_PEND: begin
                    if (cpuLastCycle) begin
                        state_q <= ABU_BREAK;
                    end
                end
                ABU_BREAK: begin
                    if (cpuRtiExec) begin
                        state_q <= ABU_IDLE;
                    end
                end
                default: begin
                    state_q <= ABU_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wakeup_q <= 1'b0;
        end else if (breakStart && inLowPower) begin
            wakeup_q <= 1'b1;
        end else if (wrWake && !regWrData[`ABU_BIT_WAKEUP]) begin
            wakeup_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // outputs toward core, timers, watchdog and peripherals
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            breakRequest <= 1'b0;
            breakActive <= 1'b0;
            lowPowerExit <= 1'b0;
            timerHalt <= 1'b0;
            watchdogHold <= 1'b0;
            flagClearAllow <= 1'b1;
            breakVector <= `ABU_VEC_NORMAL;
        end else begin
            breakRequest <= (state_q == ABU_IDLE) ? breakStart : (state_q == ABU_PEND);
            breakActive <= (state_q == ABU_BREAK) && !cpuRtiExec;
            lowPowerExit <= breakStart && inLowPower;
            timerHalt <= (state_q == ABU_BREAK) && !cpuRtiExec;
            watchdogHold <= (state_q == ABU_BREAK) && !cpuRtiExec && tstSync;
            flagClearAllow <= (state_q != ABU_BREAK) || cpuRtiExec || clearEn_q;
            breakVector <= monitorMode ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL;
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    logic [2:0] irqEvent;
    assign irqEvent = {breakStart && inLowPower, softBreak, matchHit && (state_q == ABU_IDLE)};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqStatus_q <= `ABU_RST_IRQ;
        end else if (wrIrqSt) begin
            irqStatus_q <= (irqStatus_q & ~regWrData[2:0]) | irqEvent;
        end else begin
            irqStatus_q <= irqStatus_q | irqEvent;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqMask_q <= `ABU_RST_IRQ;
        end else if (wrIrqMask) begin
            irqMask_q <= regWrData[2:0];
        end
    end

    // irq lags status by one cycle to keep the output on a flip-flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus_q & irqMask_q);
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (regRd) begin
            unique case (regAddr)
                `ABU_ADDR_STATUS_CONTROL: regRdData <= {enable_q, active_q, 6'h00};
                `ABU_ADDR_ADDR_HIGH: regRdData <= addrHigh_q;
                `ABU_ADDR_ADDR_LOW: regRdData <= addrLow_q;
                `ABU_ADDR_WAKEUP_STATUS: regRdData <= {6'h00, wakeup_q, 1'b0};
                `ABU_ADDR_FLAG_CLEAR: regRdData <= {clearEn_q, 7'h00};
                `ABU_ADDR_IRQ_STATUS: regRdData <= {5'h00, irqStatus_q};
                `ABU_ADDR_IRQ_MASK: regRdData <= {5'h00, irqMask_q};
                default: regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_match_request: assert property (@(posedge clk) disable iff (rst)
        (state_q == ABU_IDLE && enable_q && cpuPcFetch && cpuAddr == {addrHigh_q, addrLow_q}) |=> breakRequest)
        else $error("address match gave no break request");
    a_fetch_only: assert property (@(posedge clk) disable iff (rst)
        (state_q == ABU_IDLE && !cpuPcFetch && !softBreak) |=> !breakRequest)
        else $error("break request without fetch match");
    a_vector_select: assert property (@(posedge clk) disable iff (rst)
        monitorMode |=> breakVector == `ABU_VEC_MONITOR)
        else $error("wrong break vector");
    a_last_cycle: assert property (@(posedge clk) disable iff (rst)
        (breakStart && cpuLastCycle) |=> state_q == ABU_BREAK)
        else $error("break not immediate on last cycle");
    a_soft_break: assert property (@(posedge clk) disable iff (rst)
        softBreak |=> active_q)
        else $error("soft break did not set active");
    a_active_clear: assert property (@(posedge clk) disable iff (rst)
        (wrCtl && !regWrData[`ABU_BIT_ACTIVE] && !matchHit) |=> !active_q)
        else $error("active not cleared by zero write");
    a_enable_gate: assert property (@(posedge clk) disable iff (rst)
        (!enable_q && state_q == ABU_IDLE && !softBreak) |=> !breakRequest)
        else $error("break while disabled");
    a_rti_end: assert property (@(posedge clk) disable iff (rst)
        (state_q == ABU_BREAK && cpuRtiExec) |=> (state_q == ABU_IDLE) ##1 !timerHalt)
        else $error("rti did not end break");
    a_timer_halt: assert property (@(posedge clk) disable iff (rst)
        (state_q == ABU_BREAK && !cpuRtiExec) |=> timerHalt)
        else $error("timers not halted in break");
    a_watchdog_hold: assert property (@(posedge clk) disable iff (rst)
        (state_q == ABU_BREAK && !cpuRtiExec && tstSync) |=> watchdogHold)
        else $error("watchdog not held");
    a_wake_flag: assert property (@(posedge clk) disable iff (rst)
        (breakStart && inLowPower) |=> wakeup_q && lowPowerExit)
        else $error("wakeup flag not set");
    a_flag_protect: assert property (@(posedge clk) disable iff (rst)
        (state_q == ABU_BREAK && !cpuRtiExec && !clearEn_q) |=> !flagClearAllow)
        else $error("flag clear allowed in break");
    a_clear_allow: assert property (@(posedge clk) disable iff (rst)
        (state_q == ABU_BREAK && !cpuRtiExec && clearEn_q) |=> flagClearAllow)
        else $error("flag clear blocked with enable set");
    a_pend_hold: assert property (@(posedge clk) disable iff (rst)
        (state_q == ABU_PEND && !cpuLastCycle) |=> (state_q == ABU_PEND && breakRequest))
        else $error("pending break left before instruction end");
    a_match_active: assert property (@(posedge clk) disable iff (rst)
        matchHit |=> active_q)
        else $error("address match did not set active");
    a_addr_load: assert property (@(posedge clk) disable iff (rst)
        wrHigh |=> addrHigh_q == $past(regWrData))
        else $error("address high byte not loaded");
    a_wake_clear: assert property (@(posedge clk) disable iff (rst)
        (wrWake && !regWrData[`ABU_BIT_WAKEUP] && !(breakStart && inLowPower)) |=> !wakeup_q)
        else $error("wakeup flag not cleared by zero write");
    a_stop_wake: assert property (@(posedge clk) disable iff (rst)
        (breakStart && cpuInStop) |=> (state_q == ABU_BREAK && lowPowerExit && wakeup_q))
        else $error("break did not leave stop");
    a_wait_match: assert property (@(posedge clk) disable iff (rst)
        (cpuInWait && matchHit && state_q == ABU_IDLE) |=> (breakRequest && state_q == ABU_BREAK))
        else $error("match in wait mode gave no break");
endmodule : address_breakpoint_unit

// ===== testbench/abu_cpu_model.sv
`timescale 1ns/1ps
// ----
// core stand-in: fetch, instruction length, return, low power
// ----
module abu_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic goFetch,
    input wire logic goPc,
    input wire logic [15:0] goAddr,
    input wire logic [3:0] goLen,
    input wire logic goRti,
    input wire logic goWait,
    input wire logic goStop,
    input wire logic breakActive,
    input wire logic lowPowerExit,
    output logic [15:0] cpuAddr,
    output logic cpuPcFetch,
    output logic cpuLastCycle,
    output logic cpuRtiExec,
    output logic cpuInWait,
    output logic cpuInStop
);
    logic [3:0] cntQ;
    // idle bus shows the inverse of its last value so a stale match cannot linger
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpuAddr <= 16'hffff;
            cpuPcFetch <= 1'b0;
            cpuLastCycle <= 1'b0;
            cntQ <= 4'h0;
        end else if (goFetch) begin
            cpuAddr <= goAddr;
            cpuPcFetch <= goPc;
            cpuLastCycle <= (goLen == 4'h1);
            cntQ <= goLen - 4'h1;
        end else begin
            cpuAddr <= ~cpuAddr;
            cpuPcFetch <= 1'b0;
            cpuLastCycle <= (cntQ == 4'h1);
            cntQ <= (cntQ == 4'h0) ? 4'h0 : cntQ - 4'h1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpuRtiExec <= 1'b0;
            cpuInWait <= 1'b0;
            cpuInStop <= 1'b0;
        end else begin
            cpuRtiExec <= goRti & breakActive;
            cpuInWait <= goWait | (cpuInWait & ~lowPowerExit);
            cpuInStop <= goStop | (cpuInStop & ~lowPowerExit);
        end
    end
endmodule : abu_cpu_model

// ===== testbench/test_address_breakpoint_unit.sv
`timescale 1ns/1ps
`include "abu_consts.svh"
module test_address_breakpoint_unit;
    localparam logic [2:0] CTL = `ABU_ADDR_STATUS_CONTROL;
    localparam logic [2:0] WAK = `ABU_ADDR_WAKEUP_STATUS;
    localparam logic [2:0] FCL = `ABU_ADDR_FLAG_CLEAR;
    localparam logic [2:0] IST = `ABU_ADDR_IRQ_STATUS;
    localparam logic [2:0] IMK = `ABU_ADDR_IRQ_MASK;
    logic clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic monitorMode = 1'b0, testHighVoltage = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00, regRdData;
    logic [15:0] cpuAddr, breakVector, goAddr = 16'h0000;
    logic cpuPcFetch, cpuLastCycle, cpuRtiExec, cpuInWait, cpuInStop, breakRequest;
    logic breakActive, lowPowerExit, timerHalt, watchdogHold, flagClearAllow, irq;
    logic goFetch = 1'b0, goPc = 1'b0, goRti = 1'b0, goWait = 1'b0, goStop = 1'b0;
    logic [3:0] goLen = 4'h1;
    int n_fail = 0, cmp_count = 0, cycles = 0;
    address_breakpoint_unit address_breakpoint_unit_inst (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .cpuAddr(cpuAddr),
        .cpuPcFetch(cpuPcFetch), .cpuLastCycle(cpuLastCycle), .cpuRtiExec(cpuRtiExec),
        .cpuInWait(cpuInWait), .cpuInStop(cpuInStop), .monitorMode(monitorMode),
        .testHighVoltage(testHighVoltage), .breakRequest(breakRequest), .breakVector(breakVector),
        .breakActive(breakActive), .lowPowerExit(lowPowerExit), .timerHalt(timerHalt),
        .watchdogHold(watchdogHold), .flagClearAllow(flagClearAllow), .irq(irq));
    abu_cpu_model abu_cpu_model_inst (.clk(clk), .rst(rst), .goFetch(goFetch), .goPc(goPc),
        .goAddr(goAddr), .goLen(goLen), .goRti(goRti), .goWait(goWait), .goStop(goStop),
        .breakActive(breakActive), .lowPowerExit(lowPowerExit), .cpuAddr(cpuAddr),
        .cpuPcFetch(cpuPcFetch), .cpuLastCycle(cpuLastCycle), .cpuRtiExec(cpuRtiExec),
        .cpuInWait(cpuInWait), .cpuInStop(cpuInStop));
    // ----
    // bus and check helpers
    // ----
    always #5 clk = ~clk;
    task automatic final_report;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    // ceiling well above the roughly 170 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk({8'h00, regRdData}, {8'h00, exp}, what);
    endtask : rdchk
    task automatic fetch(input logic [15:0] a, input logic [3:0] len, input logic pc);
        @(posedge clk);
        goFetch <= 1'b1;
        goAddr <= a;
        goLen <= len;
        goPc <= pc;
        @(posedge clk);
        goFetch <= 1'b0;
    endtask : fetch
    task automatic waitOn(input int sel, input logic v, input string what);
        logic s;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            #1 s = (sel == 0) ? breakActive : (sel == 1) ? breakRequest : watchdogHold;
            if (s === v) return;
        end
        chk({15'h0, s}, {15'h0, v}, what);
    endtask : waitOn
    task automatic noBreak(input string what);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            #1 chk({14'h0, breakRequest, breakActive}, 16'h0, what);
        end
    endtask : noBreak
    task automatic leaveBreak(input logic [7:0] ctl);
        wr(CTL, ctl);
        wr(IST, 8'h07);
        @(posedge clk);
        goRti <= 1'b1;
        @(posedge clk);
        goRti <= 1'b0;
        waitOn(0, 1'b0, "break end");
        chk({15'h0, timerHalt}, 16'h0, "timer halt after");
    endtask : leaveBreak
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        for (int i = 0; i < 8; i++) rdchk(i[2:0], 8'h00, "reset value");
        chk({15'h0, flagClearAllow}, 16'h1, "clear allow idle");
        wr(`ABU_ADDR_ADDR_HIGH, 8'h12);
        wr(`ABU_ADDR_ADDR_LOW, 8'h34);
        wr(CTL, 8'h80);
        rdchk(`ABU_ADDR_ADDR_HIGH, 8'h12, "addr high");
        rdchk(`ABU_ADDR_ADDR_LOW, 8'h34, "addr low");
        rdchk(CTL, 8'h80, "enable");
    endtask : t_reset
    task automatic t_last;
        fetch(16'h1234, 4'h1, 1'b1);
        waitOn(1, 1'b1, "request");
        @(posedge clk);
        #1 chk({14'h0, breakActive, timerHalt}, 16'h3, "immediate break");
        chk({15'h0, watchdogHold}, 16'h0, "watchdog no voltage");
        chk(breakVector, `ABU_VEC_NORMAL, "vector");
        rdchk(CTL, 8'hc0, "active set");
        chk({15'h0, flagClearAllow}, 16'h0, "clear blocked");
        wr(FCL, 8'h80);
        rdchk(FCL, 8'h80, "clear enable");
        chk({15'h0, flagClearAllow}, 16'h1, "clear allowed");
        wr(FCL, 8'h00);
        rdchk(IST, 8'h01, "match event");
        chk({15'h0, irq}, 16'h0, "irq masked");
        wr(IMK, 8'h01);
        rdchk(IMK, 8'h01, "mask");
        chk({15'h0, irq}, 16'h1, "irq raised");
        wr(IST, 8'h01);
        rdchk(IST, 8'h00, "event cleared");
        chk({15'h0, irq}, 16'h0, "irq cleared");
        leaveBreak(8'h80);
        rdchk(CTL, 8'h80, "active cleared");
    endtask : t_last
    task automatic t_other;
        fetch(16'h1234, 4'h4, 1'b1);
        waitOn(1, 1'b1, "pending request");
        chk({15'h0, breakActive}, 16'h0, "waits for instruction end");
        waitOn(0, 1'b1, "break after instruction");
        leaveBreak(8'h80);
        fetch(16'h1234, 4'h1, 1'b0);
        noBreak("data address");
        fetch(16'h1235, 4'h1, 1'b1);
        noBreak("other address");
        wr(CTL, 8'h00);
        fetch(16'h1234, 4'h1, 1'b1);
        noBreak("disabled");
        @(posedge clk);
        monitorMode <= 1'b1;
        wr(CTL, 8'h40);
        // the writing instruction has to end before the pending soft break is taken
        fetch(16'h0000, 4'h1, 1'b0);
        waitOn(0, 1'b1, "soft break");
        chk(breakVector, `ABU_VEC_MONITOR, "monitor vector");
        rdchk(IST, 8'h02, "soft event");
        leaveBreak(8'h00);
        @(posedge clk);
        monitorMode <= 1'b0;
    endtask : t_other
    task automatic t_wake(input logic stop);
        @(posedge clk);
        testHighVoltage <= 1'b1;
        goWait <= ~stop;
        goStop <= stop;
        @(posedge clk);
        goWait <= 1'b0;
        goStop <= 1'b0;
        wr(CTL, 8'h80);
        fetch(16'h1234, 4'h1, 1'b1);
        waitOn(0, 1'b1, "break in low power");
        waitOn(2, 1'b1, "watchdog held");
        chk({14'h0, cpuInWait, cpuInStop}, 16'h0, "woken");
        rdchk(WAK, 8'h02, "wakeup flag");
        rdchk(IST, 8'h05, "wake event");
        wr(WAK, 8'h00);
        rdchk(WAK, 8'h00, "wakeup cleared");
        @(posedge clk);
        testHighVoltage <= 1'b0;
        leaveBreak(8'h80);
    endtask : t_wake
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_last();
        t_other();
        t_wake(1'b0);
        t_wake(1'b1);
        final_report();
    end
endmodule : test_address_breakpoint_unit
